// file: msr_defines.vh
/*
 Constants for the master/slave redundancy control block: register offsets,
 field positions, reset values and the priority figures forced by the select pin.
 Assumes inclusion by bare name from the design file.
*/
`ifndef MSR_DEFINES_VH
`define MSR_DEFINES_VH

`define ADDR_LOCAL_VALID_LOW 8'h0e
`define ADDR_LOCAL_VALID_HIGH 8'h0f
`define ADDR_PRIO_FIRST 8'h18
`define ADDR_PRIO_LAST 8'h1e
`define ADDR_REMOTE_VALID_LOW 8'h30
`define ADDR_REMOTE_VALID_HIGH 8'h31
`define ADDR_AUX_PRIO_FIRST 8'h40
`define ADDR_AUX_PRIO_LAST 8'h46
`define ADDR_MODE_CTRL 8'h48
`define ADDR_STATUS 8'h49
`define ADDR_SYNC_CTRL 8'h4a
`define ADDR_EFFECTIVE 8'h4b

`define PRIO_XC_INDEX 3'h5
`define PRIO_FORCED 4'h1
`define PRIO_OFF 4'h0

`define MODE_PBO_BIT 2
`define MODE_PBO_ALT_BIT 4
`define MODE_REVERT_BIT 0
`define MODE_BW_AUTO_BIT 1
`define MODE_BW_ACQ_BIT 3
`define MODE_RESET 8'h01

`define SYNC_EXT_EN_BIT 0
`define SYNC_RESET 8'h00

`define PRIO_RESET 8'h00
`define VALID_RESET 8'h00
`define SYNC_PERIOD 16'h0c7f
`define LOCK_DELAY_CYCLES 8'h0f
`endif

// file: msr_ctrl.v
/*
 Master/slave redundancy control: register file, select-pin overrides of
 priority, phase rebuild, revertive and bandwidth settings, merged source
 validity and frame realignment from a sampled external sync.
 Assumes a same-clock register master and asynchronous pins/clocks at the edge.
*/
// The plain strobed port was left to the implementer.
// How it works
// - Master: cross-connect input eleven priority follows its register; zero disables it.
// - Master: phase rebuild, revertive and bandwidth follow registers, auto or manual.
// - Slave: main-path cross-connect input eleven forced to priority 1.
// - Slave: phase rebuild forced off.
// - Slave: revertive mode forced on.
// - Slave: main-path bandwidth forced to acquisition setting.
// - Overridden settings stay software controllable; pin gives hardware control.
// - Sources flagged invalid remotely are treated invalid alongside local monitoring.
// - Main and auxiliary paths keep separate priority tables.
// - Phase rebuild off and locked: output at f is in phase with reference.
// - Faster outputs falling-edge aligned to f; slower ones divide f.
// - Auxiliary outputs relate only to auxiliary input unless locked to main.
// - Cross-connect at 19.44 MHz aligns that rate and multiples only.
// - Locking to multiframe sync aligns all; frame sync aligns all but 2 kHz.
// - External sync is sampled by reference clock, only realigns dividers.
// - Output phase offset applies in master mode only when both rebuild bits are off, and always in slave mode.
`timescale 1ns/1ps
`default_nettype none
`include "msr_defines.vh"
module msr_ctrl #(
    parameter NSRC = 14,
    parameter NPRIO = 7,
    parameter DIV_MAX = `SYNC_PERIOD
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    input wire master_slave_select_pin,
    input wire [NSRC-1:0] local_source_ok,
    input wire ref_lock,
    input wire aux_locked_to_main,
    input wire reference_clock,
    input wire external_sync_input,
    output reg [NSRC-1:0] source_valid,
    output reg [3:0] main_xc_priority,
    output reg [3:0] aux_xc_priority,
    output reg phase_rebuild_en,
    output reg revertive_en,
    output reg bw_use_acq,
    output reg phase_offset_en,
    output reg frame_realign,
    output reg multiframe_sync_output,
    output reg frame_sync_output
);
    // Stored registers; the pin never touches these
    reg [7:0] prio_q [0:NPRIO-1];
    reg [7:0] aux_prio_q [0:NPRIO-1];
    reg [7:0] remote_lo_q;
    reg [7:0] remote_hi_q;
    reg [7:0] mode_q;
    reg [7:0] sync_ctrl_q;
    reg [1:0] sel_sync_q;
    reg [NSRC-1:0] src_meta_q;
    reg [NSRC-1:0] src_sync_q;
    reg [1:0] lock_sync_q;
    reg [1:0] aux_lock_sync_q;
    reg [1:0] rclk_sync_q;
    reg [1:0] xsync_sync_q;
    reg rclk_prev_q;
    reg xs_sampled_q;
    reg xs_prev_q;
    reg [15:0] div_q;
    reg [1:0] mf_q;
    reg [7:0] lock_cnt_q;
    wire is_master;
    wire rclk_rise;
    wire xs_fall;
    wire [2:0] pidx;
    wire [2:0] aidx;
    wire [NSRC-1:0] remote_valid;
    wire [15:0] remote_word;
    wire [15:0] local_word;
    wire [NSRC-1:0] merged_valid;
    wire bw_acq_prog;
    wire [7:0] prio_off;
    wire [7:0] aux_off;
    wire in_prio;
    wire in_aux;
    wire rebuild_prog;
    wire [7:0] status_word;
    wire [7:0] effective_word;
    integer i;
    genvar g;

    assign is_master = sel_sync_q[1];
    // Offsets are formed at full width and then cut, so a table base need not be aligned
    assign prio_off = addr - `ADDR_PRIO_FIRST;
    assign aux_off = addr - `ADDR_AUX_PRIO_FIRST;
    assign pidx = prio_off[2:0];
    assign aidx = aux_off[2:0];
    assign in_prio = (addr >= `ADDR_PRIO_FIRST) && (addr <= `ADDR_PRIO_LAST);
    assign in_aux = (addr >= `ADDR_AUX_PRIO_FIRST) && (addr <= `ADDR_AUX_PRIO_LAST);
    assign remote_word = {remote_hi_q, remote_lo_q};
    assign remote_valid = remote_word[NSRC-1:0];
    // Unused upper source positions read back as zero
    assign local_word = {{(16-NSRC){1'b0}}, src_sync_q};
    // Either rebuild control bit turns phase rebuild on in master mode
    assign rebuild_prog = mode_q[`MODE_PBO_BIT] | mode_q[`MODE_PBO_ALT_BIT];
    assign status_word = {4'h0, aux_lock_sync_q[1], lock_sync_q[1], 1'b0, is_master};
    assign effective_word = {main_xc_priority, bw_use_acq, revertive_en, phase_offset_en, phase_rebuild_en};

    // Per source: the remote flag can only withdraw a source, never add one
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : valid_bit
            assign merged_valid[g] = src_sync_q[g] & remote_valid[g];
        end
    endgenerate

    assign rclk_rise = rclk_sync_q[1] & ~rclk_prev_q;
    assign xs_fall = xs_prev_q & ~xs_sampled_q;
    // Auto picks acquisition until lock has held a while, manual uses the bit
    assign bw_acq_prog = mode_q[`MODE_BW_AUTO_BIT] ? (lock_cnt_q != `LOCK_DELAY_CYCLES)
                                                   : mode_q[`MODE_BW_ACQ_BIT];

    // Two flip-flops on everything from outside the ref_clk domain
    // Select pin: the device counts as slave until the pin has been seen high
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_sync_q <= 2'h0;
        end else begin
            sel_sync_q <= {sel_sync_q[0], master_slave_select_pin};
        end
    end

    // Local source monitors
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_meta_q <= {NSRC{1'b0}};
            src_sync_q <= {NSRC{1'b0}};
        end else begin
            src_meta_q <= local_source_ok;
            src_sync_q <= src_meta_q;
        end
    end

    // Lock status of both paths
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_sync_q <= 2'h0;
            aux_lock_sync_q <= 2'h0;
        end else begin
            lock_sync_q <= {lock_sync_q[0], ref_lock};
            aux_lock_sync_q <= {aux_lock_sync_q[0], aux_locked_to_main};
        end
    end

    // Sync starts at its idle high level so no false fall follows reset
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rclk_sync_q <= 2'h0;
            xsync_sync_q <= 2'h3;
        end else begin
            rclk_sync_q <= {rclk_sync_q[0], reference_clock};
            xsync_sync_q <= {xsync_sync_q[0], external_sync_input};
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < NPRIO; i = i + 1) begin
                prio_q[i] <= `PRIO_RESET;
                aux_prio_q[i] <= `PRIO_RESET;
            end
            remote_lo_q <= `VALID_RESET;
            remote_hi_q <= `VALID_RESET;
            mode_q <= `MODE_RESET;
            sync_ctrl_q <= `SYNC_RESET;
        end else if (wr_stb) begin
            // Software keeps full control of stored values in either pin state
            // Local valid registers have no write path: they mirror the monitors
            if (in_prio) begin
                prio_q[pidx] <= wdata;
            end
            if (in_aux) begin
                aux_prio_q[aidx] <= wdata;
            end
            if (addr == `ADDR_REMOTE_VALID_LOW) begin
                remote_lo_q <= wdata;
            end
            if (addr == `ADDR_REMOTE_VALID_HIGH) begin
                remote_hi_q <= wdata;
            end
            if (addr == `ADDR_MODE_CTRL) begin
                mode_q <= wdata;
            end
            if (addr == `ADDR_SYNC_CTRL) begin
                sync_ctrl_q <= wdata;
            end
        end
    end

    // Lock qualification for automatic bandwidth selection
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_q <= 8'h00;
        end else if (!lock_sync_q[1]) begin
            lock_cnt_q <= 8'h00;
        end else if (lock_cnt_q != `LOCK_DELAY_CYCLES) begin
            lock_cnt_q <= lock_cnt_q + 8'h01;
        end
    end

    // Effective settings: the pin overrides the main-path settings here, not source_valid, aux_xc_priority or the registers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            source_valid <= {NSRC{1'b0}};
        end else begin
            source_valid <= merged_valid;
        end
    end

    // The aux table has no pin override, so the aux path may drop the partner input
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_xc_priority <= `PRIO_OFF;
        end else begin
            aux_xc_priority <= aux_prio_q[`PRIO_XC_INDEX][3:0];
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_xc_priority <= `PRIO_OFF;
        end else if (is_master) begin
            main_xc_priority <= prio_q[`PRIO_XC_INDEX][3:0];
        end else begin
            main_xc_priority <= `PRIO_FORCED;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_rebuild_en <= 1'b0;
        end else if (is_master) begin
            phase_rebuild_en <= rebuild_prog;
        end else begin
            phase_rebuild_en <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            revertive_en <= 1'b0;
        end else if (is_master) begin
            revertive_en <= mode_q[`MODE_REVERT_BIT];
        end else begin
            revertive_en <= 1'b1;
        end
    end

    // A slave must track its master closely, so acquisition bandwidth is forced there
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bw_use_acq <= 1'b1;
        end else if (is_master) begin
            bw_use_acq <= bw_acq_prog;
        end else begin
            bw_use_acq <= 1'b1;
        end
    end

    // An offset is usable only while rebuild cannot move the phase on its own
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_offset_en <= 1'b0;
        end else if (is_master) begin
            phase_offset_en <= ~rebuild_prog;
        end else begin
            phase_offset_en <= 1'b1;
        end
    end

    // External sync is sampled on reference rises, never locked to
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rclk_prev_q <= 1'b0;
            xs_sampled_q <= 1'b1;
            xs_prev_q <= 1'b1;
        end else begin
            rclk_prev_q <= rclk_sync_q[1];
            if (rclk_rise) begin
                xs_sampled_q <= xsync_sync_q[1];
                xs_prev_q <= xs_sampled_q;
            end
        end
    end

    // Frame dividers count reference rises; slower syncs are divisions of f
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 16'h0000;
            mf_q <= 2'h0;
            frame_realign <= 1'b0;
            frame_sync_output <= 1'b1;
            multiframe_sync_output <= 1'b1;
        end else begin
            frame_realign <= 1'b0;
            if (rclk_rise) begin
                if (sync_ctrl_q[`SYNC_EXT_EN_BIT] && xs_fall) begin
                    // Only the falling edge realigns; the lock path is untouched
                    div_q <= 16'h0000;
                    mf_q <= 2'h0;
                    frame_realign <= 1'b1;
                end else if (div_q == DIV_MAX) begin
                    div_q <= 16'h0000;
                    mf_q <= mf_q + 2'h1;
                end else begin
                    div_q <= div_q + 16'h0001;
                end
                // Falling edges of both syncs come one reference rise after a divider wrap
                // Only the reference rate lines up across a pair; divided rates need a sync
                frame_sync_output <= (div_q >= (DIV_MAX >> 1));
                multiframe_sync_output <= (mf_q[1] == 1'b1);
            end
        end
    end

    // Read data stand one cycle and then drop to zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (!rd_stb) begin
            rdata <= 8'h00;
        end else if (in_prio) begin
            rdata <= prio_q[pidx];
        end else if (in_aux) begin
            rdata <= aux_prio_q[aidx];
        end else begin
            case (addr)
                `ADDR_LOCAL_VALID_LOW: begin
                    rdata <= local_word[7:0];
                end
                `ADDR_LOCAL_VALID_HIGH: begin
                    rdata <= local_word[15:8];
                end
                `ADDR_REMOTE_VALID_LOW: begin
                    rdata <= remote_lo_q;
                end
                `ADDR_REMOTE_VALID_HIGH: begin
                    rdata <= remote_hi_q;
                end
                `ADDR_MODE_CTRL: begin
                    rdata <= mode_q;
                end
                `ADDR_SYNC_CTRL: begin
                    rdata <= sync_ctrl_q;
                end
                `ADDR_STATUS: begin
                    rdata <= status_word;
                end
                `ADDR_EFFECTIVE: begin
                    rdata <= effective_word;
                end
                default: begin
                    rdata <= 8'h00;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: msr_ctrl_monitor.sv
/*
 Concurrent checks on the port behaviour of the master/slave redundancy block.
 Assumes it is bound to every msr_ctrl instance and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module msr_ctrl_monitor #(
    parameter NSRC = 14
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_stb,
    input wire logic master_slave_select_pin,
    input wire logic [NSRC-1:0] local_source_ok,
    input wire logic [NSRC-1:0] source_valid,
    input wire logic [3:0] main_xc_priority,
    input wire logic [3:0] aux_xc_priority,
    input wire logic phase_rebuild_en,
    input wire logic revertive_en,
    input wire logic bw_use_acq,
    input wire logic phase_offset_en,
    input wire logic frame_realign
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Four low samples cover the two-stage synchroniser plus the output register
    sequence s_slave;
        (!master_slave_select_pin)[*4];
    endsequence
    a_slave_prio: assert property (s_slave |-> main_xc_priority == 4'h1) else $error("slave priority not forced");
    a_slave_rebuild: assert property (s_slave |-> !phase_rebuild_en) else $error("slave rebuild not off");
    a_slave_revert: assert property (s_slave |-> revertive_en) else $error("slave revertive not on");
    a_slave_bw: assert property (s_slave |-> bw_use_acq) else $error("slave bandwidth not acquisition");
    a_offset_gate: assert property (phase_offset_en |-> !phase_rebuild_en) else $error("offset with rebuild on");
    a_valid_merge: assert property ((source_valid & ~(local_source_ok | $past(local_source_ok)
        | $past(local_source_ok, 2) | $past(local_source_ok, 3) | $past(local_source_ok, 4))) == '0)
        else $error("source valid without local validity");
    a_realign_pulse: assert property (frame_realign |=> !frame_realign) else $error("realign pulse too long");
    a_aux_no_override: assert property (!$past(wr_stb) && !$past(wr_stb, 2) && !$past(wr_stb, 3)
        |-> $stable(aux_xc_priority)) else $error("aux priority moved without a write");
    c_slave_return: cover property (s_slave ##1 master_slave_select_pin);
    c_realign: cover property (frame_realign);
    c_valid: cover property (|source_valid);
endmodule
bind msr_ctrl msr_ctrl_monitor #(.NSRC(NSRC)) mon (.ref_clk(ref_clk), .rst_n(rst_n), .wr_stb(wr_stb),
    .master_slave_select_pin(master_slave_select_pin), .local_source_ok(local_source_ok),
    .source_valid(source_valid), .main_xc_priority(main_xc_priority), .aux_xc_priority(aux_xc_priority),
    .phase_rebuild_en(phase_rebuild_en), .revertive_en(revertive_en), .bw_use_acq(bw_use_acq),
    .phase_offset_en(phase_offset_en), .frame_realign(frame_realign));
`default_nettype wire

// file: far_timing_device.sv
/*
 Partner timing device: free-running reference clock and a multiframe sync.
 Assumes the block samples the sync at reference clock rises.
*/
`timescale 1ns/1ps
`default_nettype none
module far_timing_device (
    output logic reference_clock,
    output logic external_sync_input
);
    int n;
    initial begin
        reference_clock = 1'b0;
        external_sync_input = 1'b1;
        n = 0;
        forever begin
            #160 reference_clock = 1'b1;
            #160 reference_clock = 1'b0;
            n = (n + 1) % 16;
            // Changed on the falling edge so that each rise samples a settled level
            external_sync_input = (n < 8);
        end
    end
endmodule
`default_nettype wire

// file: tb.sv
/*
 Self-checking bench for the master/slave redundancy block.
 Assumes the partner model drives the reference clock and sync.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, pin = 1'b1, ref_lock = 1'b0;
    logic aux_lock = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [13:0] local_ok = 14'h0000, source_valid;
    logic [3:0] mprio, aprio;
    logic rebuild, revert, acq, offen, realign, mfs, fs;
    wire refc, esync;
    int fails = 0, n_compared = 0;
    msr_ctrl #(.DIV_MAX(16'h0007)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .master_slave_select_pin(pin),
        .local_source_ok(local_ok), .ref_lock(ref_lock), .aux_locked_to_main(aux_lock), .reference_clock(refc),
        .external_sync_input(esync), .source_valid(source_valid), .main_xc_priority(mprio),
        .aux_xc_priority(aprio), .phase_rebuild_en(rebuild), .revertive_en(revert), .bw_use_acq(acq),
        .phase_offset_en(offen), .frame_realign(realign), .multiframe_sync_output(mfs), .frame_sync_output(fs));
    far_timing_device far (.reference_clock(refc), .external_sync_input(esync));
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 chk("read data", {8'h00, rdata}, {8'h00, exp});
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task eff(input logic [3:0] p, input logic rb, input logic rv, input logic aq, input logic of);
        chk("main priority", {12'h000, mprio}, {12'h000, p});
        chk("settings", {12'h000, rebuild, revert, acq, offen}, {12'h000, rb, rv, aq, of});
    endtask
    task t_master;
        wr(8'h1d, 8'h03);
        wr(8'h48, 8'h04);
        wait_n(3);
        eff(4'h3, 1'b1, 1'b0, 1'b0, 1'b0);
        wr(8'h48, 8'h10);
        wait_n(3);
        eff(4'h3, 1'b1, 1'b0, 1'b0, 1'b0);
        wr(8'h1d, 8'h00);
        wr(8'h48, 8'h08);
        wait_n(3);
        eff(4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
        wr(8'h48, 8'h02);
        wait_n(3);
        chk("auto acquisition", {15'h0000, acq}, 16'h0001);
        ref_lock <= 1'b1;
        wait_n(25);
        chk("auto locked", {15'h0000, acq}, 16'h0000);
    endtask
    task t_slave;
        wr(8'h48, 8'h04);
        pin <= 1'b0;
        wait_n(4);
        eff(4'h1, 1'b0, 1'b1, 1'b1, 1'b1);
        rd(8'h1d, 8'h00);
        rd(8'h48, 8'h04);
        pin <= 1'b1;
        wait_n(4);
        eff(4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask
    task t_valid;
        local_ok <= 14'h0ff0;
        wait_n(4);
        chk("valid remote clear", {2'b00, source_valid}, 16'h0000);
        wr(8'h30, 8'ha5);
        wr(8'h31, 8'h3c);
        wait_n(3);
        chk("valid merged", {2'b00, source_valid}, 16'h0ca0);
        rd(8'h0e, 8'hf0);
        rd(8'h0f, 8'h0f);
        wr(8'h0e, 8'h00);
        rd(8'h0e, 8'hf0);
        rd(8'h20, 8'h00);
        rd(8'h30, 8'ha5);
    endtask
    task t_aux;
        wr(8'h45, 8'h07);
        wr(8'h1d, 8'h02);
        wait_n(3);
        chk("aux priority", {12'h000, aprio}, 16'h0007);
        wr(8'h48, 8'h08);
        pin <= 1'b0;
        aux_lock <= 1'b1;
        wait_n(4);
        rd(8'h4b, 8'h1e);
        rd(8'h49, 8'h0c);
        chk("aux under slave", {12'h000, aprio}, 16'h0007);
        chk("main under slave", {12'h000, mprio}, 16'h0001);
        pin <= 1'b1;
        wait_n(4);
    endtask
    task t_sync;
        logic hit, pf, pm;
        int nm, bad;
        hit = 1'b0;
        wr(8'h4a, 8'h01);
        for (int k = 0; k < 600 && !hit; k++) begin
            wait_n(1);
            hit = realign;
        end
        chk("realign seen", {15'h0000, hit}, 16'h0001);
        wr(8'h4a, 8'h00);
        wait_n(10);
        hit = 1'b0;
        pf = fs;
        pm = mfs;
        nm = 0;
        bad = 0;
        for (int k = 0; k < 600; k++) begin
            wait_n(1);
            hit = hit | realign;
            if (pm && !mfs) begin
                nm++;
                if (!(pf && !fs))
                    bad++;
            end
            pf = fs;
            pm = mfs;
        end
        chk("realign disabled", {15'h0000, hit}, 16'h0000);
        chk("multiframe falls", {15'h0000, nm > 0}, 16'h0001);
        chk("multiframe off frame", bad[15:0], 16'h0000);
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Tests need at most about 1320 cycles; the 20000-cycle time limit lies about fifteen times above that
    initial begin
        #800000;
        fails++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_master;
        t_slave;
        t_valid;
        t_aux;
        t_sync;
        complete_run;
    end
endmodule
`default_nettype wire
